// ### hdl/adc_wake_pkg.sv
package adc_wake_pkg;
   localparam int          DATA_W        = 12;
   localparam logic [4:0]  EDGE_FULL     = 5'h10;  // 16th falling edge
   localparam logic [4:0]  EDGE_SLEEP_LO = 5'h02;
   localparam logic [4:0]  EDGE_SLEEP_HI = 5'h0a;
   localparam logic [4:0]  EDGE_CONV_END = 5'h0d;  // b0 shifted out here
   localparam logic [4:0]  EDGE_TRACK    = 5'h0e;  // hold released in operation
   localparam logic [4:0]  EDGE_LAST_BIT = 5'h0f;
   localparam int          CLK_MHZ       = 25;
   localparam int          WAKE_FAST_NS  = 333;
   localparam int          WAKE_SLOW_NS  = 1000;
   // both times round down, at least one cycle
   localparam int          WAKE_FAST_CYC = (WAKE_FAST_NS * CLK_MHZ / 1000 < 1) ? 1 :
                                           WAKE_FAST_NS * CLK_MHZ / 1000;
   localparam int          WAKE_SLOW_CYC = (WAKE_SLOW_NS * CLK_MHZ / 1000 < 1) ? 1 :
                                           WAKE_SLOW_NS * CLK_MHZ / 1000;
   localparam logic [11:0] SAMPLE_RST    = 12'h000;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_WAKE  = 2'b01,
      ST_AWAKE = 2'b11
   } power_t;
endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; stage one is read by stage two only
module pin_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic rst_val,
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   // next values of both stages
   always_comb begin
      nxt_meta = din;
      nxt_sync = meta_ff;
   end

   // reset value chosen per pin; both constants so no port feeds reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta ^ rst_val;
         sync_ff <= nxt_sync;
      end
   end

   assign dout = sync_ff ^ rst_val;
endmodule // pin_sync

// ### hdl/adc_sleep_wake_sequencer.sv
`timescale 1ns/1ps
// converter-side sleep/wake and frame sequencing, all logic on clk
module adc_sleep_wake_sequencer (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        fast_variant,
   input  wire logic [11:0] sample_in,
   output logic             sdo_o,
   output logic             sdo_oe,
   output logic             track,
   output logic             powered,
   output logic             asleep,
   output logic             result_valid,
   output logic             wake_too_short
);
   logic cs_n_s;
   logic sck_s;

   // both pins come from the host; select idles high, clock idles high
   pin_sync u_cs (
      .clk     (clk),
      .reset   (reset),
      .rst_val (1'b1),
      .din     (cs_n),
      .dout    (cs_n_s)
   );
   pin_sync u_sck (
      .clk     (clk),
      .reset   (reset),
      .rst_val (1'b1),
      .din     (sck),
      .dout    (sck_s)
   );

   adc_wake_pkg::power_t state_ff;
   adc_wake_pkg::power_t nxt_state;
   logic        cs_prev_ff;
   logic        nxt_cs_prev;
   logic        sck_prev_ff;
   logic        nxt_sck_prev;
   logic [4:0]  edge_ff;
   logic [4:0]  nxt_edge;
   logic [15:0] shift_ff;
   logic [15:0] nxt_shift;
   logic        oe_ff;
   logic        nxt_oe;
   logic        track_ff;
   logic        nxt_track;
   logic        valid_ff;
   logic        nxt_valid;
   logic [10:0] wake_cyc_ff;
   logic [10:0] nxt_wake_cyc;
   logic        short_ff;
   logic        nxt_short;
   logic        frame_ff;
   logic        nxt_frame;
   logic        fall;
   logic        cs_fall;
   logic        cs_rise;
   logic [10:0] wake_need;

   assign fall    = sck_prev_ff & ~sck_s & ~cs_n_s;
   assign cs_fall = cs_prev_ff & ~cs_n_s;
   assign cs_rise = ~cs_prev_ff & cs_n_s;
   // minimum wake time for the chosen variant, in clk cycles
   assign wake_need = fast_variant ? 11'(adc_wake_pkg::WAKE_FAST_CYC)
                                   : 11'(adc_wake_pkg::WAKE_SLOW_CYC);

   // frame, power and sample-and-hold sequencing
   always_comb begin
      nxt_state    = state_ff;
      nxt_cs_prev  = cs_n_s;
      nxt_sck_prev = sck_s;
      nxt_edge     = edge_ff;
      nxt_shift    = shift_ff;
      nxt_oe       = oe_ff;
      nxt_track    = track_ff;
      nxt_valid    = 1'b0;
      nxt_wake_cyc = wake_cyc_ff;
      nxt_short    = short_ff;
      nxt_frame    = frame_ff;
      if (cs_fall) begin
         // select low: hold, enable output, first leading zero out
         nxt_frame    = 1'b1;
         nxt_edge     = 5'h00;
         nxt_oe       = 1'b1;
         nxt_track    = 1'b0;
         nxt_wake_cyc = 11'h000;
         nxt_shift    = {2'b00, sample_in, 2'b00};
         if (state_ff == adc_wake_pkg::ST_SLEEP) begin
            nxt_state = adc_wake_pkg::ST_WAKE;
         end
      end else if (frame_ff && cs_rise) begin
         nxt_frame = 1'b0;
         nxt_oe    = 1'b0;
         if (state_ff == adc_wake_pkg::ST_AWAKE && edge_ff >= adc_wake_pkg::EDGE_SLEEP_LO &&
             edge_ff <= adc_wake_pkg::EDGE_SLEEP_HI) begin
            nxt_state = adc_wake_pkg::ST_SLEEP;
            nxt_track = 1'b0;
         end else if (state_ff == adc_wake_pkg::ST_WAKE) begin
            // wake frame cut short: stay asleep
            nxt_state = adc_wake_pkg::ST_SLEEP;
            nxt_track = 1'b0;
         end else begin
            nxt_track = 1'b1;
         end
      end else if (frame_ff) begin
         if (state_ff == adc_wake_pkg::ST_WAKE && wake_cyc_ff != 11'h7ff) begin
            nxt_wake_cyc = wake_cyc_ff + 11'h001;
         end
         if (fall && edge_ff != adc_wake_pkg::EDGE_FULL) begin
            nxt_edge  = edge_ff + 5'h01;
            nxt_shift = {shift_ff[14:0], 1'b0};
            if (state_ff == adc_wake_pkg::ST_WAKE && edge_ff == 5'h00) begin
               nxt_track = 1'b1;
            end
            if (state_ff == adc_wake_pkg::ST_AWAKE &&
                edge_ff + 5'h01 == adc_wake_pkg::EDGE_TRACK) begin
               nxt_track = 1'b1;
            end
            if (state_ff == adc_wake_pkg::ST_AWAKE &&
                edge_ff + 5'h01 == adc_wake_pkg::EDGE_CONV_END) begin
               nxt_valid = 1'b1;
            end
            if (edge_ff + 5'h01 == adc_wake_pkg::EDGE_FULL) begin
               nxt_oe = 1'b0;
               if (state_ff == adc_wake_pkg::ST_WAKE) begin
                  nxt_state = adc_wake_pkg::ST_AWAKE;
                  // wake frame shorter than the variant's minimum wake time
                  nxt_short = (wake_cyc_ff < wake_need);
               end
            end
         end
      end
   end

   // registers; power-on lands in sleep with hold engaged
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff    <= adc_wake_pkg::ST_SLEEP;
         cs_prev_ff  <= 1'b1;
         sck_prev_ff <= 1'b1;
         edge_ff     <= 5'h00;
         shift_ff    <= 16'h0000;
         oe_ff       <= 1'b0;
         track_ff    <= 1'b0;
         valid_ff    <= 1'b0;
         wake_cyc_ff <= 11'h000;
         short_ff    <= 1'b0;
         frame_ff    <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         cs_prev_ff  <= nxt_cs_prev;
         sck_prev_ff <= nxt_sck_prev;
         edge_ff     <= nxt_edge;
         shift_ff    <= nxt_shift;
         oe_ff       <= nxt_oe;
         track_ff    <= nxt_track;
         valid_ff    <= nxt_valid;
         wake_cyc_ff <= nxt_wake_cyc;
         short_ff    <= nxt_short;
         frame_ff    <= nxt_frame;
      end
   end

   // msb first; enable drops at the 16th edge or on select high
   assign sdo_o          = shift_ff[15];
   assign sdo_oe         = oe_ff;
   assign track          = track_ff;
   assign powered        = (state_ff == adc_wake_pkg::ST_AWAKE);
   assign asleep         = (state_ff != adc_wake_pkg::ST_AWAKE);
   assign result_valid   = valid_ff;
   assign wake_too_short = short_ff;
endmodule // adc_sleep_wake_sequencer

// ### sim/adc_wake_checker_sva.sv
`timescale 1ns/1ps
// port checks; pin sync gives a few cycles of slack
module adc_wake_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic track,
   input wire logic powered,
   input wire logic asleep,
   input wire logic result_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_ASLEEP_INV: assert property (asleep == !powered) else $error("asleep flag wrong");
   AST_HOLD_ASLEEP: assert property ((asleep && !sdo_oe)[*3] |-> !track)
      else $error("tracks while asleep");
   AST_POWER_ON: assert property ($rose(powered) |-> $fell(sdo_oe)) else $error("early power");
   AST_OE_START: assert property ($rose(sdo_oe) |-> !sdo_o && !track)
      else $error("bad first bit");
   AST_TRACK_FRAME: assert property ($rose(track) && asleep |-> sdo_oe) else $error("track");
   AST_VALID_AWAKE: assert property (result_valid |-> powered && sdo_oe) else $error("valid");
   AST_VALID_ONE: assert property (result_valid |=> !result_valid) else $error("pulse");
   AST_SLEEP_ABORT: assert property ($fell(powered) |-> $fell(sdo_oe)) else $error("sleep");
   AST_OE_CS: assert property (cs_n[*6] |-> !sdo_oe) else $error("sdo not off");
   // main scenarios reached
   cover property ($rose(powered));
   cover property ($fell(powered));
   cover property (result_valid);
endmodule // adc_wake_checker

bind adc_sleep_wake_sequencer adc_wake_checker adc_wake_checker_i (.clk(clk), .reset(reset),
   .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .track(track), .powered(powered),
   .asleep(asleep), .result_valid(result_valid));

// ### sim/host_link_model.sv
`timescale 1ns/1ps
// host side: select plus a 320 ns serial clock that idles high between frames
module host_link_model (
   output logic      cs_n,
   output logic      sck,
   input  wire logic sdo_o,
   input  wire logic sdo_oe,
   input  wire logic track
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b1;
   end
   // n falls; bits read just before each fall, an undriven line reads as x
   task automatic frame(input int n, output logic [15:0] word, output logic [1:0] trk);
      word = 16'h0000;
      trk  = 2'b00;
      #13 cs_n = 1'b0;
      #320;
      for (int k = 0; k < n; k++) begin
         word = {word[14:0], sdo_oe ? sdo_o : 1'bx};
         if (k < 2) trk[k] = track;
         sck = 1'b0;
         #160 sck = 1'b1;
         #160;
      end
      cs_n = 1'b1;
      #400;
   endtask
endmodule // host_link_model

// ### sim/adc_sleep_wake_sequencer_tb_top.sv
`timescale 1ns/1ps
// directed run: wake, back-to-back frames, abort to sleep, early end
module adc_sleep_wake_sequencer_tb_top;
   logic        clk, reset, fast_variant;
   logic [11:0] sample_in;
   logic [15:0] word;
   logic [1:0]  trk;
   int          n_errors = 0;
   int          checked  = 0;
   int          pulses   = 0;
   wire logic   cs_n, sck, sdo_o, sdo_oe, track, powered, asleep, result_valid, wake_too_short;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // result pulses, counted for the per-frame figure
   // sampled on the falling edge so the registered pulse is settled, never raced
   always @(negedge clk) if (result_valid === 1'b1) pulses++;

   adc_sleep_wake_sequencer adc_sleep_wake_sequencer_i (.clk(clk), .reset(reset), .cs_n(cs_n),
      .sck(sck), .fast_variant(fast_variant), .sample_in(sample_in), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .track(track), .powered(powered), .asleep(asleep),
      .result_valid(result_valid), .wake_too_short(wake_too_short));
   host_link_model host_link_model_i (.cs_n(cs_n), .sck(sck), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .track(track));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // inputs change a fixed 1 ns after the edge
   task automatic frame(input logic fast, input logic [11:0] s, input int n);
      @(posedge clk);
      #1 fast_variant = fast;
      sample_in = s;
      host_link_model_i.frame(n, word, trk);
   endtask

   task automatic scn_short_wake;
      frame(1'b0, 12'h000, 15);
      check("short wake power", powered, 1'b0);
      check("short wake track", trk, 2'b10);
      check("hold after", track, 1'b0);
   endtask
   task automatic scn_wake(input logic fast);
      frame(fast, 12'h000, 16);
      check("wake track", trk, 2'b10);
      check("powered", powered, 1'b1);
      check("wake length", wake_too_short, 1'b0);
      word = 16'h0000;
   endtask
   task automatic scn_back_to_back;
      int p;
      p = pulses;
      frame(1'b0, 12'ha5c, 16);
      check("word a", word, {2'b00, 12'ha5c, 2'b00});
      frame(1'b0, 12'h3f1, 16);
      check("word b", word, {2'b00, 12'h3f1, 2'b00});
      check("awake track", trk, 2'b00);
      check("pulses", 16'(pulses - p), 16'h0002);
   endtask
   task automatic scn_abort;
      frame(1'b0, 12'h000, 5);
      check("abort power", powered, 1'b0);
      check("abort hold", track, 1'b0);
   endtask
   task automatic scn_early_end;
      frame(1'b1, 12'h000, 12);
      check("end power", powered, 1'b1);
      check("end sdo", sdo_oe, 1'b0);
   endtask

   initial begin
      reset = 1'b1;
      fast_variant = 1'b0;
      sample_in = 12'h000;
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      check("start asleep", {powered, asleep, sdo_oe, track}, 4'b0100);
      scn_short_wake;
      scn_wake(1'b0);
      scn_back_to_back;
      scn_abort;
      scn_wake(1'b1);
      scn_early_end;
      complete_run;
   end
   // guard against a hang
   initial begin
      #2000000 n_errors++;
      complete_run;
   end
endmodule // adc_sleep_wake_sequencer_tb_top
